// file: logic/mpcs_paging_select.sv
// Overview of operation
// - each line-assignment bit makes its pin an expansion line when one, GPIO when zero
// - an expansion bit other than lines 15:13 used by neither window leaves its pin free for GPIO
// - assigned but unused lines 15:13 carry the matching cpu address bit
// - two-bit window size: off, 8K, 16K or 32K
// - bank count follows size: 64, 32 or 16 banks
// - base field gives the top three bits of the window start
// - bases align to size; 32K windows sit at 0, 0x4000 or 0x8000
// - an address inside a window drives that window's bank bits out
// - a bank bit reaches its pin only when that pin is assigned
// - each chip select asserts when the cpu hits its range
// - chip selects work only in expanded mode; unused pins stay GPIO
// - io and general select polarity and assertion phase are programmable
// - each select may stretch its bus cycle by zero to three clocks
// - io select covers 4K at 0x1000 or 8K at 0x0000, reset disabled
// - program select enabled at reset, active low, address-valid, top-of-memory sizes
// - priority bit picks general selects over program select, default program wins
// - general selects have nine sizes, off, or follow window 1 or 2
// - general selects decode anywhere from their own base register
// - general select phase defaults to clock high; polarity defaults active low
// - select 1 may be ORed onto the select 2 pin
// - either general select may be ORed onto the program select pin
// - source bit picks cpu address or expanded address for general decode
// - window 1 wins where windows overlap
// - 32K window at 0x4000 drives inverted address bit 14 on line 14
`timescale 1ns/1ps
`default_nettype none

module mpcs_paging_select (
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_in,
  input  wire mpcs_pkg::mpcs_bus_req_t bus_req_in,
  output logic [7:0]                  bus_rdata_out,
  input  wire logic [15:0]            cpu_addr_in,
  input  wire logic                   phase_clk_in,
  input  wire logic                   addr_valid_in,
  input  wire logic                   expanded_mode_in,
  output logic [5:0]                  expansion_address_lines_out,
  output logic [5:0]                  expansion_line_enable_out,
  output mpcs_pkg::mpcs_selects_t     select_pins_out,
  output mpcs_pkg::mpcs_selects_t     select_pin_enable_out,
  output logic [1:0]                  stretch_cycles_out
);
  import mpcs_pkg::*;

  mpcs_state_t state_reg;
  mpcs_state_t state_next;

  // window fields
  logic [1:0]  w1_size;
  logic [1:0]  w2_size;
  logic [2:0]  w1_base;
  logic [2:0]  w2_base;
  logic        w1_hit;
  logic        w2_raw_hit;
  logic        w2_hit;
  logic [5:0]  w1_used;
  logic [5:0]  w2_used;
  logic        w1_at_4000;
  logic        w2_at_4000;
  logic [5:0]  line_value;
  logic [5:0]  line_in_use;
  logic [18:0] exp_addr;

  // select fields
  logic        io_en;
  logic        io_pol;
  logic        io_av;
  logic        io_size;
  logic        gp_priority;
  logic        prog_en;
  logic [1:0]  prog_size;
  logic        io_range;
  logic        prog_range;
  logic        gp1_range;
  logic        gp2_range;
  logic        io_act;
  logic        prog_act;
  logic        gp1_act;
  logic        gp2_act;
  logic        prog_pin_act;
  logic        gp2_pin_act;
  logic        phase_high;

  function automatic logic win_hit(input logic [1:0] sz, input logic [2:0] b,
                                   input logic [15:0] a);
    logic r;
    r = 1'b0;
    case (sz)
      MPCS_WIN_8K:  r = (a[15:13] == b);
      MPCS_WIN_16K: r = (a[15:14] == b[2:1]);
      MPCS_WIN_32K:
      begin
        if (b[2])
          r = a[15];
        else if (b[1])
          r = (a[15] != a[14]);
        else
          r = !a[15];
      end
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // expansion lines carrying bank bits; fewer banks for larger windows
  function automatic logic [5:0] win_used(input logic [1:0] sz);
    logic [5:0] m;
    m = 6'h00;
    case (sz)
      MPCS_WIN_8K:  m = 6'h3F;
      MPCS_WIN_16K: m = 6'h3E;
      MPCS_WIN_32K: m = 6'h3C;
      default:      m = 6'h00;
    endcase
    return m;
  endfunction

  function automatic logic gp_hit(input logic [3:0] sz, input logic [7:0] base,
                                  input logic mx, input logic [18:0] a,
                                  input logic f1, input logic f2);
    logic r;
    r = 1'b1;
    if (sz == MPCS_GP_OFF)
      r = 1'b0;
    else if (sz == MPCS_GP_FOLLOW1)
      r = f1;
    else if (sz == MPCS_GP_FOLLOW2)
      r = f2;
    else if (sz < MPCS_GP_512K)
    begin
      for (int j = 0; j < 8; j++)
      begin
        if ((j + 1 >= int'(sz)) && (mx || (j + MPCS_GP_BASE_LSB <= MPCS_CPU_TOP_BIT)))
        begin
          if (a[j + MPCS_GP_BASE_LSB] != base[j])
            r = 1'b0;
        end
      end
    end
    return r;
  endfunction

  assign w1_size     = state_reg.size_sel[1:0];
  assign w2_size     = state_reg.size_sel[5:4];
  assign w1_base     = state_reg.base_sel[3:1];
  assign w2_base     = state_reg.base_sel[7:5];
  assign io_en       = state_reg.sel_ctrl[7];
  assign io_pol      = state_reg.sel_ctrl[6];
  assign io_av       = state_reg.sel_ctrl[5];
  assign io_size     = state_reg.sel_ctrl[4];
  assign gp_priority = state_reg.sel_ctrl[3];
  assign prog_en     = state_reg.sel_ctrl[2];
  assign prog_size   = state_reg.sel_ctrl[1:0];

  always_comb
  begin
    w1_hit     = win_hit(w1_size, w1_base, cpu_addr_in);
    w2_raw_hit = win_hit(w2_size, w2_base, cpu_addr_in);
    w2_hit     = w2_raw_hit && !w1_hit;
    w1_used    = win_used(w1_size);
    w2_used    = win_used(w2_size);
    w1_at_4000 = (w1_size == MPCS_WIN_32K) && (w1_base[2:1] == 2'b01);
    w2_at_4000 = (w2_size == MPCS_WIN_32K) && (w2_base[2:1] == 2'b01);
    line_value = {3'b000, cpu_addr_in[15:13]};
    if (w1_hit)
    begin
      line_value = (state_reg.bank1 & w1_used) | (line_value & ~w1_used);
      if (w1_at_4000)
        line_value[MPCS_LINE_14] = !cpu_addr_in[14];
    end
    else if (w2_hit)
    begin
      line_value = (state_reg.bank2 & w2_used) | (line_value & ~w2_used);
      if (w2_at_4000)
        line_value[MPCS_LINE_14] = !cpu_addr_in[14];
    end
    line_in_use = w1_used | w2_used | MPCS_LOW_LINES;
    exp_addr    = {line_value, cpu_addr_in[12:0]};
  end

  assign expansion_line_enable_out   = state_reg.line_assign & line_in_use;
  assign expansion_address_lines_out = line_value & expansion_line_enable_out;

  assign phase_high = addr_valid_in && phase_clk_in;

  always_comb
  begin
    if (io_size)
      io_range = (cpu_addr_in[15:12] == 4'h1);
    else
      io_range = (cpu_addr_in[15:13] == 3'h0);
    case (prog_size)
      2'h0:    prog_range = 1'b1;
      2'h1:    prog_range = cpu_addr_in[15];
      2'h2:    prog_range = (cpu_addr_in[15:14] == 2'h3);
      default: prog_range = (cpu_addr_in[15:13] == 3'h7);
    endcase
    gp1_range = gp_hit(state_reg.gp1_ctrl[3:0], state_reg.gp1_base,
                       state_reg.size_sel[6],
                       state_reg.size_sel[6] ? exp_addr : {3'b000, cpu_addr_in},
                       w1_hit, w2_hit);
    gp2_range = gp_hit(state_reg.gp2_ctrl[3:0], state_reg.gp2_base,
                       state_reg.size_sel[7],
                       state_reg.size_sel[7] ? exp_addr : {3'b000, cpu_addr_in},
                       w1_hit, w2_hit);
    io_act   = expanded_mode_in && io_en && io_range
               && (io_av ? addr_valid_in : phase_high);
    prog_act = expanded_mode_in && prog_en && prog_range && addr_valid_in;
    gp1_act  = expanded_mode_in && gp1_range
               && (state_reg.gp1_ctrl[4] ? addr_valid_in : phase_high);
    gp2_act  = expanded_mode_in && gp2_range
               && (state_reg.gp2_ctrl[4] ? addr_valid_in : phase_high);
    if (gp_priority)
      prog_act = prog_act && !gp1_act && !gp2_act;
    else if (prog_act)
    begin
      gp1_act = 1'b0;
      gp2_act = 1'b0;
    end
    gp2_pin_act  = gp2_act || (state_reg.gp1_ctrl[6] && gp1_act);
    prog_pin_act = prog_act || (state_reg.gp1_ctrl[7] && gp1_act)
                   || (state_reg.gp2_ctrl[7] && gp2_act);
  end

  // polarity bit high means active high
  always_comb
  begin
    select_pins_out.prog = !prog_pin_act;
    select_pins_out.io   = io_pol ? io_act : !io_act;
    select_pins_out.gp1  = state_reg.gp1_ctrl[5] ? gp1_act : !gp1_act;
    select_pins_out.gp2  = state_reg.gp2_ctrl[5] ? gp2_pin_act : !gp2_pin_act;
    select_pin_enable_out.prog = expanded_mode_in && prog_en;
    select_pin_enable_out.io   = expanded_mode_in && io_en;
    select_pin_enable_out.gp1  = expanded_mode_in && (state_reg.gp1_ctrl[3:0] != MPCS_GP_OFF);
    select_pin_enable_out.gp2  = expanded_mode_in && (state_reg.gp2_ctrl[3:0] != MPCS_GP_OFF);
  end

  // longest stretch among the selects taking part in this access
  always_comb
  begin
    stretch_cycles_out = 2'h0;
    if (io_act && state_reg.stretch[7:6] > stretch_cycles_out)
      stretch_cycles_out = state_reg.stretch[7:6];
    if (prog_act && state_reg.stretch[5:4] > stretch_cycles_out)
      stretch_cycles_out = state_reg.stretch[5:4];
    if (gp1_act && state_reg.stretch[3:2] > stretch_cycles_out)
      stretch_cycles_out = state_reg.stretch[3:2];
    if (gp2_act && state_reg.stretch[1:0] > stretch_cycles_out)
      stretch_cycles_out = state_reg.stretch[1:0];
  end

  always_comb
  begin
    state_next       = state_reg;
    state_next.rdata = 8'h00;
    if (bus_req_in.wr)
    begin
      case (bus_req_in.addr)
        MPCS_OFS_LINE_ASSIGN: state_next.line_assign = bus_req_in.wdata[5:0];
        MPCS_OFS_SIZE_SEL:    state_next.size_sel    = bus_req_in.wdata;
        MPCS_OFS_BASE_SEL:    state_next.base_sel    = bus_req_in.wdata & MPCS_MASK_BASE_SEL;
        MPCS_OFS_BANK1:       state_next.bank1       = bus_req_in.wdata[5:0];
        MPCS_OFS_BANK2:       state_next.bank2       = bus_req_in.wdata[5:0];
        MPCS_OFS_STRETCH:     state_next.stretch     = bus_req_in.wdata;
        MPCS_OFS_SEL_CTRL:    state_next.sel_ctrl    = bus_req_in.wdata;
        MPCS_OFS_GP1_BASE:    state_next.gp1_base    = bus_req_in.wdata;
        MPCS_OFS_GP1_CTRL:    state_next.gp1_ctrl    = bus_req_in.wdata;
        MPCS_OFS_GP2_BASE:    state_next.gp2_base    = bus_req_in.wdata;
        MPCS_OFS_GP2_CTRL:    state_next.gp2_ctrl    = bus_req_in.wdata & MPCS_MASK_GP2_CTRL;
        default:              state_next.rdata       = 8'h00;
      endcase
    end
    if (bus_req_in.rd)
    begin
      case (bus_req_in.addr)
        MPCS_OFS_LINE_ASSIGN: state_next.rdata = {2'b00, state_reg.line_assign};
        MPCS_OFS_SIZE_SEL:    state_next.rdata = state_reg.size_sel;
        MPCS_OFS_BASE_SEL:    state_next.rdata = state_reg.base_sel;
        MPCS_OFS_BANK1:       state_next.rdata = {2'b00, state_reg.bank1};
        MPCS_OFS_BANK2:       state_next.rdata = {2'b00, state_reg.bank2};
        MPCS_OFS_STRETCH:     state_next.rdata = state_reg.stretch;
        MPCS_OFS_SEL_CTRL:    state_next.rdata = state_reg.sel_ctrl;
        MPCS_OFS_GP1_BASE:    state_next.rdata = state_reg.gp1_base;
        MPCS_OFS_GP1_CTRL:    state_next.rdata = state_reg.gp1_ctrl;
        MPCS_OFS_GP2_BASE:    state_next.rdata = state_reg.gp2_base;
        MPCS_OFS_GP2_CTRL:    state_next.rdata = state_reg.gp2_ctrl;
        default:              state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_reg          <= '0;
      state_reg.sel_ctrl <= MPCS_SEL_CTRL_RESET;
    end
    else
      state_reg <= state_next;
  end

  assign bus_rdata_out = state_reg.rdata;

  // checks
  sequence s_wr_bank1;
    bus_req_in.wr && bus_req_in.addr == MPCS_OFS_BANK1;
  endsequence

  sequence s_rd_bank1;
    bus_req_in.rd && bus_req_in.addr == MPCS_OFS_BANK1 && !bus_req_in.wr;
  endsequence

  property p_line_gpio;
    @(posedge ref_clk_in) disable iff (reset_in)
    (state_reg.line_assign == 6'h00) |-> (expansion_line_enable_out == 6'h00);
  endproperty
  a_line_gpio: assert property (p_line_gpio)
    else $error("unassigned line enabled as expansion line");

  property p_unused_free;
    @(posedge ref_clk_in) disable iff (reset_in)
    (w1_size == MPCS_WIN_OFF && w2_size == MPCS_WIN_OFF)
      |-> (expansion_line_enable_out[5:3] == 3'b000);
  endproperty
  a_unused_free: assert property (p_unused_free)
    else $error("upper line claimed with both windows off");

  property p_low_lines_cpu;
    @(posedge ref_clk_in) disable iff (reset_in)
    (!w1_hit && !w2_raw_hit && state_reg.line_assign[2:0] == 3'h7)
      |-> (expansion_address_lines_out[2:0] == cpu_addr_in[15:13]);
  endproperty
  a_low_lines_cpu: assert property (p_low_lines_cpu)
    else $error("low expansion lines do not follow cpu address");

  property p_bank_written;
    @(posedge ref_clk_in) disable iff (reset_in)
    s_wr_bank1 ##1 (w1_hit && w1_size == MPCS_WIN_8K && state_reg.line_assign == 6'h3F)
      |-> (expansion_address_lines_out == $past(bus_req_in.wdata[5:0]));
  endproperty
  a_bank_written: assert property (p_bank_written)
    else $error("window 1 bank not driven after write");

  property p_bank_readback;
    @(posedge ref_clk_in) disable iff (reset_in)
    s_wr_bank1 ##1 !bus_req_in.wr ##1 s_rd_bank1
      |=> (bus_rdata_out == {2'b00, $past(bus_req_in.wdata[5:0], 3)});
  endproperty
  a_bank_readback: assert property (p_bank_readback)
    else $error("bank register read back wrong");

  property p_overlap;
    @(posedge ref_clk_in) disable iff (reset_in)
    (w1_hit && w2_raw_hit) |-> !w2_hit;
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("window 2 active under window 1");

  property p_line14_invert;
    @(posedge ref_clk_in) disable iff (reset_in)
    (w1_hit && w1_at_4000 && state_reg.line_assign[MPCS_LINE_14])
      |-> (expansion_address_lines_out[MPCS_LINE_14] != cpu_addr_in[14]);
  endproperty
  a_line14_invert: assert property (p_line14_invert)
    else $error("line 14 not inverted for window at 0x4000");

  property p_not_expanded;
    @(posedge ref_clk_in) disable iff (reset_in)
    !expanded_mode_in |-> (select_pin_enable_out == '0 && select_pins_out.prog);
  endproperty
  a_not_expanded: assert property (p_not_expanded)
    else $error("chip select active outside expanded mode");

  property p_prog_reset;
    @(posedge ref_clk_in) disable iff (reset_in)
    $fell(reset_in) ##0 (state_reg.sel_ctrl == MPCS_SEL_CTRL_RESET) ##0
      (expanded_mode_in && addr_valid_in && !bus_req_in.wr) |-> !select_pins_out.prog;
  endproperty
  a_prog_reset: assert property (p_prog_reset)
    else $error("program select not asserted out of reset");

  property p_priority;
    @(posedge ref_clk_in) disable iff (reset_in)
    (!gp_priority && prog_act) |-> (!gp1_act && !gp2_act);
  endproperty
  a_priority: assert property (p_priority)
    else $error("general select asserted over program select");

  property p_gp1_onto_prog;
    @(posedge ref_clk_in) disable iff (reset_in)
    (state_reg.gp1_ctrl[7] && gp1_act) |-> !select_pins_out.prog;
  endproperty
  a_gp1_onto_prog: assert property (p_gp1_onto_prog)
    else $error("select 1 not seen on program pin");

endmodule // mpcs_paging_select

`default_nettype wire

// file: logic/mpcs_pkg.sv
package mpcs_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] MPCS_OFS_LINE_ASSIGN = 8'h2D;
  localparam logic [7:0] MPCS_OFS_SIZE_SEL    = 8'h56;
  localparam logic [7:0] MPCS_OFS_BASE_SEL    = 8'h57;
  localparam logic [7:0] MPCS_OFS_BANK1       = 8'h58;
  localparam logic [7:0] MPCS_OFS_BANK2       = 8'h59;
  localparam logic [7:0] MPCS_OFS_STRETCH     = 8'h5A;
  localparam logic [7:0] MPCS_OFS_SEL_CTRL    = 8'h5B;
  localparam logic [7:0] MPCS_OFS_GP1_BASE    = 8'h5C;
  localparam logic [7:0] MPCS_OFS_GP1_CTRL    = 8'h5D;
  localparam logic [7:0] MPCS_OFS_GP2_BASE    = 8'h5E;
  localparam logic [7:0] MPCS_OFS_GP2_CTRL    = 8'h5F;

  // writable-bit masks; other bits read as zero
  localparam logic [7:0] MPCS_MASK_BASE_SEL = 8'hEE;
  localparam logic [7:0] MPCS_MASK_SIX      = 8'h3F;
  localparam logic [7:0] MPCS_MASK_GP2_CTRL = 8'hBF;

  // window size codes
  localparam logic [1:0] MPCS_WIN_OFF = 2'h0;
  localparam logic [1:0] MPCS_WIN_8K  = 2'h1;
  localparam logic [1:0] MPCS_WIN_16K = 2'h2;
  localparam logic [1:0] MPCS_WIN_32K = 2'h3;

  // general select size codes
  localparam logic [3:0] MPCS_GP_OFF     = 4'h0;
  localparam logic [3:0] MPCS_GP_512K    = 4'h9;
  localparam logic [3:0] MPCS_GP_FOLLOW1 = 4'hA;
  localparam logic [3:0] MPCS_GP_FOLLOW2 = 4'hB;
  localparam int         MPCS_GP_BASE_LSB = 11;
  localparam int         MPCS_CPU_TOP_BIT = 15;

  // expansion lines 15:13 double as cpu address lines
  localparam logic [5:0] MPCS_LOW_LINES = 6'h07;
  localparam int         MPCS_LINE_14   = 1;

  // program select starts enabled
  localparam logic [7:0] MPCS_SEL_CTRL_RESET = 8'h04;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mpcs_bus_req_t;

  typedef struct packed {
    logic prog;
    logic io;
    logic gp1;
    logic gp2;
  } mpcs_selects_t;

  typedef struct packed {
    logic [5:0] line_assign;
    logic [7:0] size_sel;
    logic [7:0] base_sel;
    logic [5:0] bank1;
    logic [5:0] bank2;
    logic [7:0] stretch;
    logic [7:0] sel_ctrl;
    logic [7:0] gp1_base;
    logic [7:0] gp1_ctrl;
    logic [7:0] gp2_base;
    logic [7:0] gp2_ctrl;
    logic [7:0] rdata;
  } mpcs_state_t;

endpackage

// file: test/mpcs_ext_devices.sv
`timescale 1ns/1ps
`default_nettype none

module mpcs_ext_devices (
  input  wire mpcs_pkg::mpcs_selects_t pins_in,
  input  wire mpcs_pkg::mpcs_selects_t en_in,
  input  wire logic [3:0]              act_high_in,
  output logic [3:0]                   dev_sel_out
);
  import mpcs_pkg::*;
  // a device answers only while its pin is a chip select at its active level
  assign dev_sel_out = {en_in} & ~({pins_in} ^ act_high_in);
endmodule // mpcs_ext_devices

`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import mpcs_pkg::*;
  logic          ref_clk_in = 1'b0;
  logic          reset_in   = 1'b1;
  mpcs_bus_req_t bus_req    = '0;
  logic [15:0]   cpu_addr   = 16'h0000;
  logic          phase      = 1'b0;
  logic          addr_valid = 1'b1;
  logic          expanded   = 1'b0;
  logic [3:0]    act_high   = 4'h0;
  logic [7:0]    rdata;
  logic [5:0]    lines;
  logic [5:0]    line_en;
  mpcs_selects_t sel_pins;
  mpcs_selects_t sel_en;
  logic [1:0]    stretch;
  logic [3:0]    dev_sel;
  int            n_fail      = 0;
  int            checks_done = 0;
  int            cyc         = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  mpcs_paging_select uut (
    .ref_clk_in                  (ref_clk_in),
    .reset_in                    (reset_in),
    .bus_req_in                  (bus_req),
    .bus_rdata_out               (rdata),
    .cpu_addr_in                 (cpu_addr),
    .phase_clk_in                (phase),
    .addr_valid_in               (addr_valid),
    .expanded_mode_in            (expanded),
    .expansion_address_lines_out (lines),
    .expansion_line_enable_out   (line_en),
    .select_pins_out             (sel_pins),
    .select_pin_enable_out       (sel_en),
    .stretch_cycles_out          (stretch)
  );

  mpcs_ext_devices devs (
    .pins_in     (sel_pins),
    .en_in       (sel_en),
    .act_high_in (act_high),
    .dev_sel_out (dev_sel)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus_req <= '0;
    #2;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge ref_clk_in);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus_req <= '0;
    #2;
    chk(nm, exp, rdata);
  endtask

  task automatic ad(input logic [15:0] a, input logic ph);
    @(posedge ref_clk_in);
    cpu_addr <= a;
    phase    <= ph;
    #2;
  endtask

  task automatic t_regs();
    rd(MPCS_OFS_SEL_CTRL, 8'h04, "sel_ctrl");
    rd(MPCS_OFS_BASE_SEL, 8'h00, "base_sel");
    rd(MPCS_OFS_STRETCH, 8'h00, "stretch");
    rd(MPCS_OFS_GP1_CTRL, 8'h00, "gp1_ctrl");
    wr(MPCS_OFS_BASE_SEL, 8'hFF);
    rd(MPCS_OFS_BASE_SEL, 8'hEE, "base_sel");
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00, "unmapped");
    wr(MPCS_OFS_BASE_SEL, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_page();
    wr(MPCS_OFS_LINE_ASSIGN, 8'h3F);
    ad(16'hA000, 1'b0);
    chk("line_en", 8'h07, {2'h0, line_en});
    chk("lines", 8'h05, {2'h0, lines});
    wr(MPCS_OFS_SIZE_SEL, 8'h01);
    wr(MPCS_OFS_BASE_SEL, 8'h04);
    ad(16'h4123, 1'b0);
    wr(MPCS_OFS_BANK1, 8'h15);
    rd(MPCS_OFS_BANK1, 8'h15, "bank1");
    chk("lines", 8'h15, {2'h0, lines});
    chk("line_en", 8'h3F, {2'h0, line_en});
    ad(16'h8000, 1'b0);
    chk("lines", 8'h04, {2'h0, lines});
    wr(MPCS_OFS_LINE_ASSIGN, 8'h01);
    ad(16'h4123, 1'b0);
    chk("lines", 8'h01, {2'h0, lines});
    chk("line_en", 8'h01, {2'h0, line_en});
    $display("test page done");
  endtask

  task automatic t_win();
    wr(MPCS_OFS_LINE_ASSIGN, 8'h3F);
    wr(MPCS_OFS_SIZE_SEL, 8'h23);
    wr(MPCS_OFS_BASE_SEL, 8'hA4);
    wr(MPCS_OFS_BANK1, 8'h08);
    wr(MPCS_OFS_BANK2, 8'h33);
    ad(16'h8000, 1'b0);
    chk("lines", 8'h0A, {2'h0, lines});
    wr(MPCS_OFS_BASE_SEL, 8'hC4);
    ad(16'hC000, 1'b0);
    chk("lines", 8'h32, {2'h0, lines});
    ad(16'h4000, 1'b0);
    chk("lines", 8'h08, {2'h0, lines});
    ad(16'h2000, 1'b0);
    chk("lines", 8'h01, {2'h0, lines});
    wr(MPCS_OFS_BASE_SEL, 8'h0C);
    ad(16'hF000, 1'b0);
    chk("lines", 8'h0B, {2'h0, lines});
    ad(16'h4000, 1'b0);
    chk("lines", 8'h02, {2'h0, lines});
    ad(16'hF000, 1'b0);
    wr(MPCS_OFS_BANK1, 8'h2A);
    chk("lines", 8'h2B, {2'h0, lines});
    $display("test windows done");
  endtask

  task automatic t_cs();
    ad(16'h0000, 1'b0);
    chk("sel_en", 8'h00, {4'h0, sel_en});
    @(posedge ref_clk_in);
    expanded <= 1'b1;
    ad(16'h0000, 1'b0);
    chk("sel_en", 8'h08, {4'h0, sel_en});
    chk("dev", 8'h08, {4'h0, dev_sel});
    wr(MPCS_OFS_SEL_CTRL, 8'h07);
    ad(16'h1000, 1'b0);
    chk("dev", 8'h00, {4'h0, dev_sel});
    ad(16'hE000, 1'b0);
    chk("dev", 8'h08, {4'h0, dev_sel});
    wr(MPCS_OFS_SEL_CTRL, 8'h06);
    ad(16'hBFFF, 1'b0);
    chk("dev", 8'h00, {4'h0, dev_sel});
    ad(16'hC000, 1'b0);
    chk("dev", 8'h08, {4'h0, dev_sel});
    wr(MPCS_OFS_SEL_CTRL, 8'h90);
    ad(16'h0800, 1'b1);
    chk("dev", 8'h00, {4'h0, dev_sel});
    ad(16'h1800, 1'b0);
    chk("dev", 8'h00, {4'h0, dev_sel});
    ad(16'h1800, 1'b1);
    chk("dev", 8'h04, {4'h0, dev_sel});
    wr(MPCS_OFS_STRETCH, 8'hC0);
    chk("stretch", 8'h03, {6'h0, stretch});
    ad(16'h1800, 1'b0);
    chk("stretch", 8'h00, {6'h0, stretch});
    act_high <= 4'h4;
    wr(MPCS_OFS_SEL_CTRL, 8'hD0);
    ad(16'h1800, 1'b1);
    chk("dev", 8'h04, {4'h0, dev_sel});
    chk("io_pin", 8'h01, {7'h0, sel_pins.io});
    act_high <= 4'h0;
    wr(MPCS_OFS_SEL_CTRL, 8'hA0);
    ad(16'h0800, 1'b0);
    chk("dev", 8'h04, {4'h0, dev_sel});
    @(posedge ref_clk_in);
    addr_valid <= 1'b0;
    #2;
    chk("dev", 8'h00, {4'h0, dev_sel});
    @(posedge ref_clk_in);
    addr_valid <= 1'b1;
    $display("test selects done");
  endtask

  task automatic t_gp();
    wr(MPCS_OFS_SEL_CTRL, 8'h04);
    wr(MPCS_OFS_GP1_BASE, 8'h07);
    wr(MPCS_OFS_GP1_CTRL, 8'h01);
    wr(MPCS_OFS_GP2_BASE, 8'hFF);
    wr(MPCS_OFS_GP2_CTRL, 8'h01);
    ad(16'h3800, 1'b1);
    chk("dev", 8'h08, {4'h0, dev_sel});
    wr(MPCS_OFS_SEL_CTRL, 8'h0C);
    chk("dev", 8'h02, {4'h0, dev_sel});
    wr(MPCS_OFS_GP1_CTRL, 8'h41);
    chk("dev", 8'h03, {4'h0, dev_sel});
    wr(MPCS_OFS_GP1_CTRL, 8'h81);
    chk("dev", 8'h0A, {4'h0, dev_sel});
    wr(MPCS_OFS_SEL_CTRL, 8'h08);
    wr(MPCS_OFS_GP1_CTRL, 8'h11);
    ad(16'h3800, 1'b0);
    chk("dev", 8'h02, {4'h0, dev_sel});
    wr(MPCS_OFS_GP1_CTRL, 8'h01);
    chk("dev", 8'h00, {4'h0, dev_sel});
    ad(16'h3800, 1'b1);
    wr(MPCS_OFS_GP1_BASE, 8'h27);
    chk("dev", 8'h02, {4'h0, dev_sel});
    wr(MPCS_OFS_SIZE_SEL, 8'h40);
    chk("dev", 8'h00, {4'h0, dev_sel});
    wr(MPCS_OFS_GP1_CTRL, 8'h0A);
    wr(MPCS_OFS_SIZE_SEL, 8'h01);
    wr(MPCS_OFS_BASE_SEL, 8'h00);
    ad(16'h1000, 1'b1);
    chk("dev", 8'h02, {4'h0, dev_sel});
    ad(16'h2000, 1'b1);
    chk("dev", 8'h00, {4'h0, dev_sel});
    wr(MPCS_OFS_GP1_CTRL, 8'h0B);
    wr(MPCS_OFS_SIZE_SEL, 8'h11);
    wr(MPCS_OFS_BASE_SEL, 8'h20);
    chk("dev", 8'h02, {4'h0, dev_sel});
    $display("test general selects done");
  endtask

  task automatic t_reset();
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    #2;
    chk("prog_pin", 8'h00, {7'h0, sel_pins.prog});
    rd(MPCS_OFS_GP1_CTRL, 8'h00, "gp1_ctrl");
    rd(MPCS_OFS_SEL_CTRL, 8'h04, "sel_ctrl");
    $display("test reset done");
  endtask

  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    t_regs();
    t_page();
    t_win();
    t_cs();
    t_gp();
    t_reset();
    finish_test();
  end
endmodule // tb

`default_nettype wire
